// ### pps_pkg.sv
// constants and types shared by the power-up pin settings block
package pps_pkg;

   // register offsets on the plain register port
   localparam logic [7:0] REG_PID_LO = 8'h00;
   localparam logic [7:0] REG_PID_HI = 8'h01;
   localparam logic [7:0] REG_PWR_ATTR = 8'h02;
   localparam logic [7:0] REG_CUR_HALF = 8'h03;
   localparam logic [7:0] REG_PIN0_CFG = 8'h04;
   localparam logic [7:0] REG_PIN1_CFG = 8'h05;
   localparam logic [7:0] REG_PIN2_CFG = 8'h06;
   localparam logic [7:0] REG_CLK_DIV = 8'h07;
   localparam logic [7:0] REG_EDGE_CFG = 8'h08;
   localparam logic [7:0] REG_APPLY = 8'h09;
   localparam logic [7:0] REG_GPIO_OUT = 8'h0A;
   localparam logic [7:0] REG_GPIO_IN = 8'h0B;
   localparam logic [7:0] REG_INT_STATUS = 8'h0C;
   localparam logic [7:0] REG_INT_MASK = 8'h0D;
   localparam logic [7:0] REG_RESP_SEL = 8'h0E;
   // 64-byte response window, byte n at RESP_BASE + n
   localparam logic [7:0] RESP_BASE = 8'h40;
   localparam logic [7:0] RESP_MASK = 8'hC0;

   // response layout
   localparam logic [5:0] RB_ECHO = 6'h00;
   localparam logic [5:0] RB_STATUS = 6'h01;
   localparam logic [5:0] RB_LENGTH = 6'h02;
   localparam logic [5:0] RB_PIN0 = 6'h04;
   localparam logic [5:0] RB_PIN1 = 6'h05;
   localparam logic [5:0] RB_PIN2 = 6'h06;
   localparam logic [5:0] RB_PID_LO = 6'h0A;
   localparam logic [5:0] RB_PID_HI = 6'h0B;
   localparam logic [5:0] RB_PWR_ATTR = 6'h0C;
   localparam logic [5:0] RB_CUR_HALF = 6'h0D;
   localparam logic [7:0] CMD_FLASH_READ = 8'hB0;
   localparam logic [7:0] STATUS_OK = 8'h00;
   localparam logic [7:0] PIN_STRUCT_LEN = 8'h00; // length byte, plain default

   // pin settings byte fields
   localparam int PIN_LEVEL_BIT = 4;
   localparam int PIN_DIR_BIT = 3;
   localparam logic [7:0] PIN_USED_MASK = 8'h1F;

   // edge config field positions
   localparam int EDGE_NEG_BIT = 6;
   localparam int EDGE_POS_BIT = 5;
   localparam logic [7:0] EDGE_USED_MASK = 8'h60;
   localparam logic [7:0] DIV_USED_MASK = 8'h1F;

   // interrupt status bits
   localparam int INT_EDGE_BIT = 0;
   localparam logic [7:0] INT_USED_MASK = 8'h01;

   // reset values
   localparam logic [15:0] RST_PID = 16'h0000;
   localparam logic [7:0] RST_PWR_ATTR = 8'h00;
   localparam logic [7:0] RST_CUR_HALF = 8'h00;
   localparam logic [7:0] RST_PIN_CFG = 8'h08;
   localparam logic [4:0] RST_CLK_DIV = 5'h00;
   localparam logic [7:0] RST_EDGE_CFG = 8'h00;

   // nominal source clock for the divided clock output
   localparam int USB_CLK_MHZ = 48;

   // pin designation codes
   typedef enum logic [2:0] {
      FN_GPIO = 3'h0,
      FN_DEDICATED = 3'h1,
      FN_ALT0 = 3'h2,
      FN_ALT1 = 3'h3,
      FN_ALT2 = 3'h4
   } pps_func_t;

   // response selector
   typedef enum logic {
      RESP_CHIP = 1'b0,
      RESP_PINS = 1'b1
   } pps_resp_t;

   // one power-up pin settings byte
   typedef struct packed {
      logic [2:0] unused;
      logic level;
      logic dir_in;
      logic [2:0] func;
   } pps_pin_cfg_t;

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pps_req_t;

endpackage

// ### pps_clk_div.sv
// divided clock generator for the clock-output pin function
`timescale 1ns/1ps
module pps_clk_div #(
   parameter int DIV_W = 5
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic enable,
   input wire logic [DIV_W-1:0] divider,
   output logic clk_out_r
);

   logic [DIV_W-1:0] count_r;
   logic [DIV_W-1:0] count_nxt;
   logic wrap;

   // half period is divider cycles; zero or disabled holds low
   assign wrap = (count_r >= divider - DIV_W'(1));
   assign count_nxt = wrap ? '0 : count_r + DIV_W'(1);

   always_ff @(posedge core_clk) begin
      if (srst || !enable || divider == '0) begin
         count_r <= '0;
         clk_out_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         if (wrap) begin
            clk_out_r <= ~clk_out_r;
         end
      end
   end

endmodule

// ### pps_top.sv
// stored power-up pin settings, chip settings tail, readback and pin mux
`timescale 1ns/1ps

module pps_top #(
   parameter logic [15:0] RESET_PID = pps_pkg::RST_PID, // arbitrary neutral id
   parameter int DIV_W = 5
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] pin_in,
   output logic [2:0] pin_out,
   output logic [2:0] pin_oe,
   input wire logic usb_suspend_indicator,
   input wire logic receive_activity_led,
   input wire logic transmit_activity_led,
   input wire logic usb_dedicated_level,
   output logic [7:0] enum_power_attr,
   output logic [8:0] enum_current_ma,
   output logic [2:0] analog_input_sel,
   output logic analog_output_one,
   output logic irq
);

   // request bundle
   pps_pkg::pps_req_t req;
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // stored settings
   logic [15:0] pid_r;
   logic [7:0] pwr_attr_r;
   logic [7:0] cur_half_r;
   pps_pkg::pps_pin_cfg_t pin_cfg_r [3];
   logic [DIV_W-1:0] clk_div_r;
   logic [7:0] edge_cfg_r;
   pps_pkg::pps_resp_t resp_sel_r;

   // live state
   logic [2:0] gp_level_r;
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic edge_prev_r;
   logic [7:0] int_status_r;
   logic [7:0] int_mask_r;
   logic [7:0] rdata_r;
   logic [2:0] pin_out_r;
   logic [2:0] pin_oe_r;
   logic irq_r;
   logic [7:0] enum_attr_r;
   logic [8:0] enum_ma_r;
   logic [2:0] ain_sel_r;
   logic aout_r;

   // strip don't-care bits from a pin settings byte
   function automatic logic [7:0] pin_byte(input pps_pkg::pps_pin_cfg_t cfg);
      pin_byte = cfg & pps_pkg::PIN_USED_MASK;
   endfunction

   // write strobe for one offset
   function automatic logic wr_hit(input pps_pkg::pps_req_t r, input logic [7:0] off);
      wr_hit = r.wr && (r.addr == off);
   endfunction

   // designation compare, used by the clock, edge, gpio and analog decodes below
   function automatic logic fn_is(input logic [2:0] f, input pps_pkg::pps_func_t code);
      fn_is = (f == code);
   endfunction

   // write decode
   // unmapped offsets, input register and window decode to nothing
   wire wr_pid_lo = wr_hit(req, pps_pkg::REG_PID_LO);
   wire wr_pid_hi = wr_hit(req, pps_pkg::REG_PID_HI);
   wire wr_attr = wr_hit(req, pps_pkg::REG_PWR_ATTR);
   wire wr_cur = wr_hit(req, pps_pkg::REG_CUR_HALF);
   wire wr_div = wr_hit(req, pps_pkg::REG_CLK_DIV);
   wire wr_edge = wr_hit(req, pps_pkg::REG_EDGE_CFG);
   wire wr_apply = wr_hit(req, pps_pkg::REG_APPLY);
   wire wr_gpio = wr_hit(req, pps_pkg::REG_GPIO_OUT);
   wire wr_istat = wr_hit(req, pps_pkg::REG_INT_STATUS);
   wire wr_imask = wr_hit(req, pps_pkg::REG_INT_MASK);
   wire wr_sel = wr_hit(req, pps_pkg::REG_RESP_SEL);
   wire [2:0] wr_pin;
   assign wr_pin[0] = wr_hit(req, pps_pkg::REG_PIN0_CFG);
   assign wr_pin[1] = wr_hit(req, pps_pkg::REG_PIN1_CFG);
   assign wr_pin[2] = wr_hit(req, pps_pkg::REG_PIN2_CFG);

   // stored chip settings tail
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pid_r <= RESET_PID;
         pwr_attr_r <= pps_pkg::RST_PWR_ATTR;
         cur_half_r <= pps_pkg::RST_CUR_HALF;
         clk_div_r <= DIV_W'(pps_pkg::RST_CLK_DIV);
         edge_cfg_r <= pps_pkg::RST_EDGE_CFG;
         resp_sel_r <= pps_pkg::RESP_CHIP;
      end else begin
         if (wr_pid_lo) begin
            pid_r[7:0] <= req.wdata;
         end
         if (wr_pid_hi) begin
            pid_r[15:8] <= req.wdata;
         end
         if (wr_attr) begin
            pwr_attr_r <= req.wdata;
         end
         if (wr_cur) begin
            cur_half_r <= req.wdata;
         end
         if (wr_div) begin
            clk_div_r <= req.wdata[DIV_W-1:0];
         end
         if (wr_edge) begin
            edge_cfg_r <= req.wdata & pps_pkg::EDGE_USED_MASK;
         end
         if (wr_sel) begin
            resp_sel_r <= pps_pkg::pps_resp_t'(req.wdata[0]);
         end
      end
   end

   // per-pin stored settings, live level and input synchroniser
   // only sync2_r is read by logic; sync1_r may be metastable
   for (genvar i = 0; i < 3; i++) begin : g_pin_store
      always_ff @(posedge core_clk) begin
         if (srst) begin
            pin_cfg_r[i] <= pps_pkg::RST_PIN_CFG;
            gp_level_r[i] <= pps_pkg::RST_PIN_CFG[pps_pkg::PIN_LEVEL_BIT];
            sync1_r[i] <= 1'b0;
            sync2_r[i] <= 1'b0;
         end else begin
            if (wr_pin[i]) begin
               pin_cfg_r[i] <= req.wdata & pps_pkg::PIN_USED_MASK;
            end
            if (wr_apply) begin
               gp_level_r[i] <= pin_cfg_r[i].level;
            end else if (wr_gpio) begin
               gp_level_r[i] <= req.wdata[i];
            end
            sync1_r[i] <= pin_in[i];
            sync2_r[i] <= sync1_r[i];
         end
      end
   end

   // designation decode
   wire [2:0] fn0 = pin_cfg_r[0].func;
   wire [2:0] fn1 = pin_cfg_r[1].func;
   wire [2:0] fn2 = pin_cfg_r[2].func;
   wire p1_clk = fn_is(fn1, pps_pkg::FN_DEDICATED);
   wire p1_edge = fn_is(fn1, pps_pkg::FN_ALT2);

   // divided clock for pin one
   // single clock: output is core_clk over twice the divider
   logic div_clk;
   pps_clk_div #(
      .DIV_W(DIV_W)
   ) u_div (
      .core_clk(core_clk),
      .srst(srst),
      .enable(p1_clk),
      .divider(clk_div_r),
      .clk_out_r(div_clk)
   );

   // alternate function drive per pin: {oe, out}
   // analog, edge and ignored codes leave the pin undriven
   logic [1:0] alt0;
   logic [1:0] alt1;
   logic [1:0] alt2;
   always_comb begin
      unique case (fn0)
         pps_pkg::FN_DEDICATED: alt0 = {1'b1, usb_suspend_indicator};
         pps_pkg::FN_ALT0: alt0 = {1'b1, receive_activity_led};
         default: alt0 = 2'h0;
      endcase
   end
   always_comb begin
      unique case (fn1)
         pps_pkg::FN_DEDICATED: alt1 = {1'b1, div_clk};
         pps_pkg::FN_ALT0: alt1 = 2'h0;
         pps_pkg::FN_ALT1: alt1 = {1'b1, transmit_activity_led};
         pps_pkg::FN_ALT2: alt1 = 2'h0;
         default: alt1 = 2'h0;
      endcase
   end
   always_comb begin
      unique case (fn2)
         pps_pkg::FN_DEDICATED: alt2 = {1'b1, usb_dedicated_level};
         pps_pkg::FN_ALT0: alt2 = 2'h0;
         pps_pkg::FN_ALT1: alt2 = 2'h0;
         default: alt2 = 2'h0;
      endcase
   end
   wire [1:0] alt_drive [3];
   assign alt_drive[0] = alt0;
   assign alt_drive[1] = alt1;
   assign alt_drive[2] = alt2;

   // pin drive: gpio uses direction bit and live level, else alternate
   logic [2:0] pin_out_nxt;
   logic [2:0] pin_oe_nxt;
   for (genvar i = 0; i < 3; i++) begin : g_pin_drive
      wire is_gpio = fn_is(pin_cfg_r[i].func, pps_pkg::FN_GPIO);
      assign pin_oe_nxt[i] = is_gpio ? ~pin_cfg_r[i].dir_in : alt_drive[i][1];
      assign pin_out_nxt[i] = is_gpio ? gp_level_r[i] : alt_drive[i][0];
   end

   // analog routing: pin one, pin two analog inputs and pin two analog output
   wire [2:0] ain_nxt = {1'b0, fn_is(fn2, pps_pkg::FN_ALT0),
                         fn_is(fn1, pps_pkg::FN_ALT0)};
   wire aout_nxt = fn_is(fn2, pps_pkg::FN_ALT1);

   // edge detection on synchronised pin one
   // prev level resets low: a pin high through reset reads as one rise
   wire fall = edge_prev_r & ~sync2_r[1];
   wire rise = ~edge_prev_r & sync2_r[1];
   wire edge_set = p1_edge & ((fall & edge_cfg_r[pps_pkg::EDGE_NEG_BIT])
                   | (rise & edge_cfg_r[pps_pkg::EDGE_POS_BIT]));
   wire [7:0] set_vec = {7'h00, edge_set};
   wire [7:0] clr_vec = wr_istat ? req.wdata : 8'h00;
   // set wins over a same-cycle write-one clear
   // an edge on the clearing cycle is kept, never lost
   wire [7:0] status_nxt = ((int_status_r & ~clr_vec) | set_vec) & pps_pkg::INT_USED_MASK;
   wire irq_nxt = |(status_nxt & int_mask_r);

   // response formatting
   wire [5:0] ridx = req.addr[5:0];
   logic [7:0] chip_byte;
   logic [7:0] pins_byte;
   always_comb begin
      unique case (ridx)
         pps_pkg::RB_ECHO: chip_byte = pps_pkg::CMD_FLASH_READ;
         pps_pkg::RB_STATUS: chip_byte = pps_pkg::STATUS_OK;
         pps_pkg::RB_PID_LO: chip_byte = pid_r[7:0];
         pps_pkg::RB_PID_HI: chip_byte = pid_r[15:8];
         pps_pkg::RB_PWR_ATTR: chip_byte = pwr_attr_r;
         pps_pkg::RB_CUR_HALF: chip_byte = cur_half_r;
         default: chip_byte = 8'h00;
      endcase
   end
   always_comb begin
      unique case (ridx)
         pps_pkg::RB_ECHO: pins_byte = pps_pkg::CMD_FLASH_READ;
         pps_pkg::RB_STATUS: pins_byte = pps_pkg::STATUS_OK;
         pps_pkg::RB_LENGTH: pins_byte = pps_pkg::PIN_STRUCT_LEN;
         pps_pkg::RB_PIN0: pins_byte = pin_byte(pin_cfg_r[0]);
         pps_pkg::RB_PIN1: pins_byte = pin_byte(pin_cfg_r[1]);
         pps_pkg::RB_PIN2: pins_byte = pin_byte(pin_cfg_r[2]);
         default: pins_byte = 8'h00;
      endcase
   end
   wire [7:0] resp_byte = (resp_sel_r == pps_pkg::RESP_PINS) ? pins_byte : chip_byte;

   // register read mux
   // window tested first: its low six bits alias the register offsets
   logic [7:0] rd_mux;
   always_comb begin
      if ((req.addr & pps_pkg::RESP_MASK) == pps_pkg::RESP_BASE) begin
         rd_mux = resp_byte;
      end else begin
         unique case (req.addr)
            pps_pkg::REG_PID_LO: rd_mux = pid_r[7:0];
            pps_pkg::REG_PID_HI: rd_mux = pid_r[15:8];
            pps_pkg::REG_PWR_ATTR: rd_mux = pwr_attr_r;
            pps_pkg::REG_CUR_HALF: rd_mux = cur_half_r;
            pps_pkg::REG_PIN0_CFG: rd_mux = pin_byte(pin_cfg_r[0]);
            pps_pkg::REG_PIN1_CFG: rd_mux = pin_byte(pin_cfg_r[1]);
            pps_pkg::REG_PIN2_CFG: rd_mux = pin_byte(pin_cfg_r[2]);
            pps_pkg::REG_CLK_DIV: rd_mux = 8'(clk_div_r);
            pps_pkg::REG_EDGE_CFG: rd_mux = edge_cfg_r;
            pps_pkg::REG_GPIO_OUT: rd_mux = {5'h00, gp_level_r};
            pps_pkg::REG_GPIO_IN: rd_mux = {5'h00, sync2_r};
            pps_pkg::REG_INT_STATUS: rd_mux = int_status_r;
            pps_pkg::REG_INT_MASK: rd_mux = int_mask_r;
            pps_pkg::REG_RESP_SEL: rd_mux = {7'h00, resp_sel_r};
            default: rd_mux = 8'h00;
         endcase
      end
   end

   // doubled current for the enumeration request
   wire [8:0] ma_nxt = {cur_half_r, 1'b0};

   // live outputs, interrupt and read data
   // read data is zero outside the cycle after a read strobe
   always_ff @(posedge core_clk) begin
      if (srst) begin
         edge_prev_r <= 1'b0;
         int_status_r <= 8'h00;
         int_mask_r <= 8'h00;
         irq_r <= 1'b0;
         rdata_r <= 8'h00;
         pin_out_r <= 3'h0;
         pin_oe_r <= 3'h0;
         enum_attr_r <= 8'h00;
         enum_ma_r <= 9'h000;
         ain_sel_r <= 3'h0;
         aout_r <= 1'b0;
      end else begin
         edge_prev_r <= sync2_r[1];
         int_status_r <= status_nxt;
         if (wr_imask) begin
            int_mask_r <= req.wdata & pps_pkg::INT_USED_MASK;
         end
         irq_r <= irq_nxt;
         rdata_r <= req.rd ? rd_mux : 8'h00;
         pin_out_r <= pin_out_nxt;
         pin_oe_r <= pin_oe_nxt;
         enum_attr_r <= pwr_attr_r;
         enum_ma_r <= ma_nxt;
         ain_sel_r <= ain_nxt;
         aout_r <= aout_nxt;
      end
   end

   // outputs from flops
   assign reg_rdata = rdata_r;
   assign pin_out = pin_out_r;
   assign pin_oe = pin_oe_r;
   assign irq = irq_r;
   assign enum_power_attr = enum_attr_r;
   assign enum_current_ma = enum_ma_r;
   assign analog_input_sel = ain_sel_r;
   assign analog_output_one = aout_r;

endmodule

// ### pps_top_properties.sv
// port assertions for the power-up pin settings block
`timescale 1ns/1ps
module pps_top_properties #(
   parameter logic [15:0] RESET_PID = 16'h0000,
   parameter int DIV_W = 5
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [2:0] pin_in,
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   input wire logic usb_suspend_indicator,
   input wire logic receive_activity_led,
   input wire logic transmit_activity_led,
   input wire logic usb_dedicated_level,
   input wire logic [7:0] enum_power_attr,
   input wire logic [8:0] enum_current_ma,
   input wire logic [2:0] analog_input_sel,
   input wire logic analog_output_one,
   input wire logic irq
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);
   // decoded strobes
   wire logic win_rd = reg_rd && reg_addr[7:6] == 2'b01;
   wire logic wr_p0 = reg_wr && reg_addr == pps_pkg::REG_PIN0_CFG;
   wire logic wr_p2 = reg_wr && reg_addr == pps_pkg::REG_PIN2_CFG;
   wire logic wd_dir = reg_wdata[3];
   echo_byte_a: assert property (win_rd && reg_addr[5:0] == 6'h00 |=>
      reg_rdata == pps_pkg::CMD_FLASH_READ) else $error("echo byte wrong");
   status_byte_a: assert property (win_rd && reg_addr[5:0] == 6'h01 |=>
      reg_rdata == pps_pkg::STATUS_OK) else $error("status byte wrong");
   tail_zero_a: assert property (win_rd && reg_addr[5:0] >= 6'h0E |=>
      reg_rdata == 8'h00) else $error("unused response byte not zero");
   pin_pad_a: assert property (win_rd && reg_addr[5:0] inside {[6'h04:6'h06]} |=>
      reg_rdata[7:5] == 3'h0) else $error("pin byte top bits not zero");
   attr_copy_a: assert property (reg_wr && reg_addr == pps_pkg::REG_PWR_ATTR |->
      ##2 enum_power_attr == $past(reg_wdata, 2)) else $error("power attributes not passed");
   cur_double_a: assert property (reg_wr && reg_addr == pps_pkg::REG_CUR_HALF |->
      ##2 enum_current_ma == {$past(reg_wdata, 2), 1'b0}) else $error("current not doubled");
   pin0_ignore_a: assert property (wr_p0 && reg_wdata[2:0] >= 3'h3 |->
      ##2 !pin_oe[0] && !pin_out[0]) else $error("ignored code drives pin zero");
   pin2_ignore_a: assert property (wr_p2 && reg_wdata[2:0] >= 3'h4 |->
      ##2 !pin_oe[2] && !pin_out[2]) else $error("ignored code drives pin two");
   dac_pin_a: assert property (wr_p2 && reg_wdata[2:0] == 3'h3 |->
      ##2 analog_output_one && !pin_oe[2]) else $error("analog output select wrong");
   gpio_dir_a: assert property (wr_p0 && reg_wdata[2:0] == 3'h0 |->
      ##2 pin_oe[0] == !$past(wd_dir, 2)) else $error("pin zero direction wrong");
endmodule
bind pps_top pps_top_properties #(.RESET_PID(RESET_PID), .DIV_W(DIV_W)) u_props (
   .core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in,
   .pin_out, .pin_oe, .usb_suspend_indicator, .receive_activity_led, .transmit_activity_led,
   .usb_dedicated_level, .enum_power_attr, .enum_current_ma, .analog_input_sel,
   .analog_output_one, .irq);

// ### pps_pad_model.sv
// pad model: each pin follows the block's driver or the outside source
`timescale 1ns/1ps
module pps_pad_model (
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   input wire logic [2:0] ext_level,
   output logic [2:0] pin_in
);
   // an enabled driver wins over the outside level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ### tb.sv
// self-checking bench for the power-up pin settings block
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata, enum_power_attr;
   logic [2:0] pin_in, pin_out, pin_oe, analog_input_sel;
   logic [2:0] ext_level = 3'h0;
   logic [3:0] ded = 4'h0;
   logic [8:0] enum_current_ma;
   logic analog_output_one, irq;
   logic [15:0] lfsr = 16'h0D1F;
   int fails = 0;
   int checks_done = 0;
   int cycles = 0;
   int pid = 0, attr = 0, cur = 0;
   int cfg[3] = '{8, 8, 8};
   always #20 core_clk = ~core_clk;
   pps_top u_dut (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .pin_in, .pin_out, .pin_oe, .usb_suspend_indicator(ded[0]), .receive_activity_led(ded[1]),
      .transmit_activity_led(ded[2]), .usb_dedicated_level(ded[3]), .enum_power_attr,
      .enum_current_ma, .analog_input_sel, .analog_output_one, .irq);
   pps_pad_model u_pads (.pin_out, .pin_oe, .ext_level, .pin_in);
   // next state of the stimulus shift register
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // model of the response bytes
   function automatic logic [7:0] resp(input int sel, input int n);
      if (n == 0) return pps_pkg::CMD_FLASH_READ;
      if (n == 1) return pps_pkg::STATUS_OK;
      if (sel == 1 && n == 2) return pps_pkg::PIN_STRUCT_LEN;
      if (sel == 1 && n >= 4 && n <= 6) return 8'(cfg[n-4] & 'h1F);
      if (sel == 0 && n == 10) return 8'(pid);
      if (sel == 0 && n == 11) return 8'(pid >> 8);
      if (sel == 0 && n == 12) return 8'(attr);
      if (sel == 0 && n == 13) return 8'(cur);
      return 8'h00;
   endfunction
   // model of {analog sel, analog out, oe, out} for one pin
   function automatic logic [5:0] mux_exp(input int p);
      logic [2:0] c;
      c = cfg[p][2:0];
      if (c == 3'h0) return {4'h0, ~cfg[p][3], cfg[p][4]};
      if (p == 0 && c == 3'h1) return {5'h01, ded[0]};
      if (p == 0 && c == 3'h2) return {5'h01, ded[1]};
      if (p == 1 && c == 3'h1) return 6'h02;
      if (p == 1 && c == 3'h2) return 6'h08;
      if (p == 1 && c == 3'h3) return {5'h01, ded[2]};
      if (p == 2 && c == 3'h1) return {5'h01, ded[3]};
      if (p == 2 && c == 3'h2) return 6'h10;
      if (p == 2 && c == 3'h3) return 6'h04;
      return 6'h00;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
   endtask
   // select a response and compare all 64 bytes
   task automatic check_resp(input int sel);
      logic [7:0] d;
      wr(pps_pkg::REG_RESP_SEL, 8'(sel));
      for (int n = 0; n < 64; n++) begin
         rd(pps_pkg::RESP_BASE + 8'(n), d);
         chk(16'(d), 16'(resp(sel, n)));
      end
   endtask
   // move pin one, then read status and irq
   task automatic edge_step(input logic lvl, input logic [7:0] st, input logic irq_exp);
      logic [7:0] d;
      @(posedge core_clk);
      ext_level[1] <= lvl;
      repeat (6) @(posedge core_clk);
      rd(pps_pkg::REG_INT_STATUS, d);
      chk(16'(d), 16'(st));
      chk(16'(irq), 16'(irq_exp));
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         print_verdict();
      end
   end
   // main sequence
   initial begin
      logic [7:0] d;
      int last, per;
      logic prev;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      for (int p = 0; p < 3; p++) begin
         rd(pps_pkg::REG_PIN0_CFG + 8'(p), d);
         chk(16'(d), 16'h0008);
      end
      wr(8'h30, 8'hFF);
      rd(8'h30, d);
      chk(16'(d), 16'h0000);
      check_resp(0);
      lfsr = lfsr_next(lfsr);
      pid = int'(lfsr);
      lfsr = lfsr_next(lfsr);
      attr = int'(lfsr[7:0]);
      cur = int'(lfsr[15:8]);
      wr(pps_pkg::REG_PID_LO, 8'(pid));
      wr(pps_pkg::REG_PID_HI, 8'(pid >> 8));
      wr(pps_pkg::REG_PWR_ATTR, 8'(attr));
      wr(pps_pkg::REG_CUR_HALF, 8'(cur));
      check_resp(0);
      chk(16'(enum_power_attr), 16'(attr));
      chk(16'(enum_current_ma), 16'(cur * 2));
      for (int p = 0; p < 3; p++) begin
         lfsr = lfsr_next(lfsr);
         cfg[p] = int'(lfsr[7:0] | 8'hE0);
         wr(pps_pkg::REG_PIN0_CFG + 8'(p), 8'(cfg[p]));
      end
      check_resp(1);
      // every designation code on every pin, the others parked as inputs
      wr(pps_pkg::REG_CLK_DIV, 8'h00);
      for (int p = 0; p < 3; p++) begin
         cfg[p] = 8;
         wr(pps_pkg::REG_PIN0_CFG + 8'(p), 8'h08);
      end
      for (int p = 0; p < 3; p++) begin
         for (int c = 0; c < 8; c++) begin
            lfsr = lfsr_next(lfsr);
            cfg[p] = int'({3'h0, lfsr[5:4], 3'(c)});
            wr(pps_pkg::REG_PIN0_CFG + 8'(p), 8'(cfg[p]));
            ded <= lfsr[9:6];
            wr(pps_pkg::REG_APPLY, 8'h01);
            repeat (3) @(posedge core_clk);
            @(negedge core_clk);
            chk(16'({analog_input_sel, analog_output_one, pin_oe[p], pin_out[p]}),
               16'(mux_exp(p)));
         end
         cfg[p] = 8;
         wr(pps_pkg::REG_PIN0_CFG + 8'(p), 8'h08);
      end
      // live level register, then pin zero driven and read back synchronised
      wr(pps_pkg::REG_GPIO_OUT, 8'h05);
      rd(pps_pkg::REG_GPIO_OUT, d);
      chk(16'(d), 16'h0005);
      wr(pps_pkg::REG_PIN0_CFG, 8'h00);
      repeat (4) @(posedge core_clk);
      rd(pps_pkg::REG_GPIO_IN, d);
      chk(16'(d), 16'h0001);
      wr(pps_pkg::REG_PIN0_CFG, 8'h08);
      // divided clock on pin one
      wr(pps_pkg::REG_CLK_DIV, 8'h02);
      wr(pps_pkg::REG_PIN1_CFG, 8'h01);
      last = -1;
      per = 0;
      prev = 1'b0;
      for (int i = 0; i < 40; i++) begin
         @(negedge core_clk);
         if (pin_out[1] && !prev) begin
            if (last >= 0) per = i - last;
            last = i;
         end
         prev = pin_out[1];
      end
      chk(16'(per), 16'h0004);
      // edge detection, then clear and mask
      wr(pps_pkg::REG_PIN1_CFG, 8'h04);
      wr(pps_pkg::REG_EDGE_CFG, 8'h40);
      wr(pps_pkg::REG_INT_MASK, 8'h01);
      wr(pps_pkg::REG_INT_STATUS, 8'h01);
      edge_step(1'b1, 8'h00, 1'b0);
      edge_step(1'b0, 8'h01, 1'b1);
      wr(pps_pkg::REG_INT_STATUS, 8'h01);
      edge_step(1'b0, 8'h00, 1'b0);
      wr(pps_pkg::REG_INT_MASK, 8'h00);
      wr(pps_pkg::REG_EDGE_CFG, 8'h20);
      edge_step(1'b1, 8'h01, 1'b0);
      print_verdict();
   end
endmodule
